// ---- verif/cond_branch_decode_tb.sv ----
// self-checking bench for the condition and branch decode block
`timescale 1ns/100ps
module cond_branch_decode_tb
   import cbd_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [CBD_ADDR_W-1:0] awaddr = '0;
   logic [CBD_ADDR_W-1:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int n_fail = 0;
   int check_count = 0;
   logic [31:0] seed = 32'hB946;
   logic [31:0] lk [CBD_BANKS];

   // ==========================================
   // clock and design
   always #5 aclk = ~aclk;

   cbd_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));

   // ==========================================
   // helpers
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic hang();
      n_fail++;
      $display("FAIL at %0t wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
      tally_and_finish();
   endtask

   // write one word, holding each channel until its ready
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (n > 50) hang();
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask

   // read one word
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (n > 50) hang();
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // launch one instruction and wait until the sequencer is idle
   task automatic run(input logic [31:0] pc, input logic [31:0] ins, output logic [31:0] st);
      logic [1:0] r;
      int n;
      n = 0;
      wr(CBD_OFF_PC, pc, r);
      wr(CBD_OFF_INSTR, ins, r);
      do begin
         rd(CBD_OFF_STATUS, st, r);
         n++;
         if (n > 20) hang();
      end while (st[CBD_ST_BUSY] !== 1'b0);
   endtask

   // expected outcome of a condition code against n z c v
   function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
      logic n, z, cy, v;
      n = f[CBD_FLAG_N];
      z = f[CBD_FLAG_Z];
      cy = f[CBD_FLAG_C];
      v = f[CBD_FLAG_V];
      case (c)
         4'h0: return z;
         4'h1: return !z;
         4'h2: return cy;
         4'h3: return !cy;
         4'h4: return n;
         4'h5: return !n;
         4'h6: return v;
         4'h7: return !v;
         4'h8: return cy && !z;
         4'h9: return !cy || z;
         4'hA: return n == v;
         4'hB: return n != v;
         4'hC: return !z && (n == v);
         4'hD: return z || (n != v);
         4'hE: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] st_exp(input logic ex, input logic tk, input logic ln,
                                          input logic nv, input logic ud);
      logic [31:0] s;
      s = '0;
      s[CBD_ST_EXEC] = ex;
      s[CBD_ST_TAKEN] = tk;
      s[CBD_ST_LINKED] = ln;
      s[CBD_ST_NEVER] = nv;
      s[CBD_ST_UNDEF] = ud;
      s[CBD_ST_FCNT_LO +: 2] = tk ? 2'h3 : 2'h1;
      return s;
   endfunction

   // ==========================================
   // main sequence
   initial begin
      logic [31:0] d, pc, st, f, tgt, ins;
      logic [1:0] r, bk;
      logic [23:0] off;
      logic ln, ex;
      for (int i = 0; i < CBD_BANKS; i++) lk[i] = '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values, unmapped place, ignored link write
      for (int a = 0; a < 6; a++) begin
         rd(8'(a * 4), d, r);
         chk(d, 32'h0);
      end
      rd(8'h18, d, r);
      chk({d[31:2], r}, {30'h0, CBD_RESP_SLVERR});
      wr(8'h18, rnd(), r);
      chk({30'h0, r}, {30'h0, CBD_RESP_SLVERR});
      wr(CBD_OFF_LINK, rnd(), r);
      chk({30'h0, r}, {30'h0, CBD_RESP_OKAY});
      rd(CBD_OFF_LINK, d, r);
      chk(d, 32'h0);
      $display("test reset done");
      // every condition with a flag set and its inverse, branch or link
      // no never class or untrapped codes here
      for (int c = 0; c < 15; c++) begin
         for (int k = 0; k < 2; k++) begin
            d = rnd();
            f = (k == 0) ? rnd() : ~f;
            bk = d[1:0];
            ln = d[24];
            off = 24'(rnd());
            if (c == 0) off = 24'hFFFFFE;
            if (c == 14) off = k ? 24'h7FFFFF : 24'h800000;
            pc = rnd() & 32'hFFFF_FFFC;
            wr(CBD_OFF_FLAGS, {28'h0, f[3:0]}, r);
            wr(CBD_OFF_BANK, {30'h0, bk}, r);
            ins = {4'(c), 3'b101, ln, off};
            run(pc, ins, st);
            ex = cond_ok(4'(c), f[3:0]);
            tgt = pc + 32'h8 + {{6{off[23]}}, off, 2'b00};
            if (ex && ln) lk[bk] = pc + 32'h4;
            chk(st, st_exp(ex, ex, ex && ln, 1'b0, 1'b0));
            rd(CBD_OFF_PC, d, r);
            chk(d, ex ? tgt : pc + 32'h4);
            rd(CBD_OFF_LINK, d, r);
            chk(d, lk[bk]);
            rd(CBD_OFF_FLAGS, d, r);
            chk(d, {28'h0, f[3:0]});
         end
      end
      $display("test conditions and branches done");
      // move of register zero onto itself as no-op
      pc = 32'h0000_1000;
      run(pc, 32'hE1A00000, st);
      chk(st, st_exp(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
      rd(CBD_OFF_PC, d, r);
      chk(d, pc + 32'h4);
      run(pc, 32'hE00000D0, st);
      chk(st, st_exp(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
      run(pc, 32'hE6000010, st);
      chk(st, st_exp(1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
      // never class sent on purpose, link must stay
      run(pc, 32'hFB000010, st);
      chk(st, st_exp(1'b0, 1'b0, 1'b0, 1'b1, 1'b1));
      rd(CBD_OFF_LINK, d, r);
      chk(d, lk[bk]);
      wr(CBD_OFF_STATUS, 32'h0000_0030, r);
      rd(CBD_OFF_STATUS, d, r);
      chk(d, st_exp(1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
      $display("test special encodings done");
      tally_and_finish();
   end
endmodule

// ---- verilog/cbd_link_mem.sv ----
// banked link register store with registered read data
`timescale 1ns/100ps
module cbd_link_mem
   import cbd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic we,
   input wire logic [CBD_BANK_W-1:0] waddr,
   input wire logic [31:0] wdata,
   input wire logic [CBD_BANK_W-1:0] raddr,
   output logic [31:0] rdata
);

   cbd_lmem_t m_q;
   cbd_lmem_t m_d;

   // ==========================================
   // next state: one write port, one read port
   always_comb begin
      m_d = m_q;
      if (we) begin
         m_d.word[waddr] = wdata;
      end
      m_d.rdata = m_q.word[raddr];
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         m_q <= '0;
      end else begin
         m_q <= m_d;
      end
   end

   assign rdata = m_q.rdata;

endmodule

// ---- verilog/cbd_pkg.sv ----
// constants and types shared by the condition and branch decode block
package cbd_pkg;

   // ==========================================
   // bus geometry
   localparam int CBD_ADDR_W = 8;
   localparam int CBD_DATA_W = 32;
   localparam int CBD_BANKS = 4;
   localparam int CBD_BANK_W = 2;

   // ==========================================
   // register byte offsets
   localparam logic [7:0] CBD_OFF_INSTR = 8'h00;
   localparam logic [7:0] CBD_OFF_PC = 8'h04;
   localparam logic [7:0] CBD_OFF_FLAGS = 8'h08;
   localparam logic [7:0] CBD_OFF_BANK = 8'h0C;
   localparam logic [7:0] CBD_OFF_STATUS = 8'h10;
   localparam logic [7:0] CBD_OFF_LINK = 8'h14;

   // ==========================================
   // field positions
   localparam int CBD_FLAG_N = 3;
   localparam int CBD_FLAG_Z = 2;
   localparam int CBD_FLAG_C = 1;
   localparam int CBD_FLAG_V = 0;
   localparam int CBD_ST_BUSY = 0;
   localparam int CBD_ST_EXEC = 1;
   localparam int CBD_ST_TAKEN = 2;
   localparam int CBD_ST_LINKED = 3;
   localparam int CBD_ST_NEVER = 4;
   localparam int CBD_ST_UNDEF = 5;
   localparam int CBD_ST_FCNT_LO = 8;

   // ==========================================
   // instruction encodings
   localparam logic [3:0] CBD_COND_EQUAL = 4'h0;
   localparam logic [3:0] CBD_COND_ALWAYS = 4'hE;
   localparam logic [3:0] CBD_COND_NEVER = 4'hF;
   localparam logic [2:0] CBD_CLASS_BRANCH = 3'h5;
   localparam logic [2:0] CBD_CLASS_UNDEF = 3'h3;
   localparam logic [5:0] CBD_MUL_TOP = 6'h00;
   localparam logic [3:0] CBD_MUL_ODD_LOW = 4'hD;

   // ==========================================
   // timing and arithmetic constants
   localparam logic [1:0] CBD_BRANCH_FETCHES = 2'h3;
   localparam logic [1:0] CBD_PLAIN_FETCHES = 2'h1;
   localparam logic [31:0] CBD_PREFETCH_BYTES = 32'h0000_0008;
   localparam logic [31:0] CBD_WORD_BYTES = 32'h0000_0004;
   localparam logic [1:0] CBD_RESP_OKAY = 2'h0;
   localparam logic [1:0] CBD_RESP_SLVERR = 2'h2;

   // ==========================================
   // sequencer states, one-hot
   typedef enum logic [2:0] {
      CBD_IDLE = 3'b001,
      CBD_EVAL = 3'b010,
      CBD_FETCH = 3'b100
   } cbd_fsm_t;

   // decoded fields of one instruction word
   typedef struct packed {
      logic [3:0] cond;
      logic [2:0] cls;
      logic link;
      logic [23:0] offset;
   } cbd_dec_t;

   // whole state of the top module
   typedef struct packed {
      cbd_fsm_t fsm;
      logic [31:0] instr;
      logic [31:0] pc;
      logic [3:0] flags;
      logic [CBD_BANK_W-1:0] bank;
      logic exec;
      logic taken;
      logic linked;
      logic never_seen;
      logic undef_trap;
      logic [1:0] fetch_cnt;
      logic aw_have;
      logic [CBD_ADDR_W-1:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } cbd_state_t;

   localparam cbd_state_t CBD_STATE_RST = '{fsm: CBD_IDLE, default: '0};

   // whole state of the link register store
   typedef struct packed {
      logic [CBD_BANKS-1:0][31:0] word;
      logic [31:0] rdata;
   } cbd_lmem_t;

endpackage

// ---- verilog/cbd_top.sv ----
// condition evaluation and branch decode with an axi4-lite register slave
//
// Operation
// RULE1 - evaluate condition against n z c v flags, execute only when satisfied
// RULE2 - always condition executes whatever the flags hold
// RULE3 - instruction source never supplies never-class conditions
// RULE4 - equal condition executes only while zero flag is set
// RULE5 - branch offset shifted left two, sign-extended, added to pc
// RULE6 - branch base pc is instruction address plus eight bytes
// RULE7 - branch with link writes link register of the active bank
// RULE8 - saved return address is address of the following instruction
// RULE9 - link action leaves every status flag untouched
// RULE10 - plain branch leaves link register unchanged
// RULE11 - branch and branch with link take exactly three fetch cycles
// RULE12 - odd multiply encoding with bit six set raises no undefined trap
// RULE13 - instruction source avoids undefined but untrapped encodings
// RULE14 - source uses move of register zero onto itself as no-op
// RULE15 - condition decoded from instruction bits 31 down to 28
// RULE16 - branch when bits 27..25 are 101, bit 24 link, 23..0 offset
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module cbd_top
   import cbd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [CBD_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [CBD_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   cbd_state_t st_q;
   cbd_state_t st_d;
   cbd_dec_t dec;
   logic pass_w;
   logic br_w;
   logic mul_odd_w;
   logic [31:0] target_w;
   logic [31:0] ret_w;
   logic lm_we;
   logic [31:0] lm_rdata;
   logic wr_go;
   logic [31:0] wr_val;
   logic wr_hit;

   // ==========================================
   // helpers

   // condition check against n z c v
   function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
      logic n;
      logic z;
      logic cy;
      logic v;
      n = f[CBD_FLAG_N];
      z = f[CBD_FLAG_Z];
      cy = f[CBD_FLAG_C];
      v = f[CBD_FLAG_V];
      case (c)
         // RULE4 equal needs zero
         4'h0: cond_pass = z;
         4'h1: cond_pass = !z;
         4'h2: cond_pass = cy;
         4'h3: cond_pass = !cy;
         4'h4: cond_pass = n;
         4'h5: cond_pass = !n;
         4'h6: cond_pass = v;
         4'h7: cond_pass = !v;
         4'h8: cond_pass = cy && !z;
         4'h9: cond_pass = !cy || z;
         4'hA: cond_pass = (n == v);
         4'hB: cond_pass = (n != v);
         4'hC: cond_pass = !z && (n == v);
         4'hD: cond_pass = z || (n != v);
         // RULE2 always executes
         4'hE: cond_pass = 1'b1;
         default: cond_pass = 1'b0;
      endcase
   endfunction

   // merge write data under byte strobes
   function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      merge_strb = r;
   endfunction

   // ==========================================
   // instruction decode
   // RULE15 condition field
   // RULE16 class, link and offset fields
   assign dec = '{cond: st_q.instr[31:28], cls: st_q.instr[27:25],
                  link: st_q.instr[24], offset: st_q.instr[23:0]};
   // RULE1 gate on flags
   // RULE3 never class simply fails here
   assign pass_w = cond_pass(dec.cond, st_q.flags);
   assign br_w = (dec.cls == CBD_CLASS_BRANCH);
   // RULE12 odd multiply pattern, excluded from the trap
   assign mul_odd_w = (st_q.instr[27:22] == CBD_MUL_TOP) && (st_q.instr[7:4] == CBD_MUL_ODD_LOW);
   // RULE5 sign-extended word offset
   // RULE6 base is two words past the instruction
   assign target_w = st_q.pc + CBD_PREFETCH_BYTES + {{6{dec.offset[23]}}, dec.offset, 2'b00};
   // RULE8 return address is the next instruction
   assign ret_w = st_q.pc + CBD_WORD_BYTES;
   // RULE7 write link of the active bank
   // RULE10 only when the link bit is set
   assign lm_we = (st_q.fsm == CBD_EVAL) && pass_w && br_w && dec.link;

   // ==========================================
   // write decode
   assign wr_go = st_q.aw_have && st_q.w_have && !st_q.bvalid && (st_q.fsm == CBD_IDLE);
   assign wr_hit = (st_q.aw_addr == CBD_OFF_INSTR) || (st_q.aw_addr == CBD_OFF_PC) ||
                   (st_q.aw_addr == CBD_OFF_FLAGS) || (st_q.aw_addr == CBD_OFF_BANK) ||
                   (st_q.aw_addr == CBD_OFF_STATUS) || (st_q.aw_addr == CBD_OFF_LINK);
   assign wr_val = st_q.w_data;

   // ==========================================
   // next state
   always_comb begin
      st_d = st_q;
      // address and data channels, taken in either order
      if (s_axi_awvalid && st_q.awready) begin
         st_d.aw_have = 1'b1;
         st_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_q.wready) begin
         st_d.w_have = 1'b1;
         st_d.w_data = s_axi_wdata;
         st_d.w_strb = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      // register writes, stalled while an instruction is in flight
      if (wr_go) begin
         st_d.aw_have = 1'b0;
         st_d.w_have = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = wr_hit ? CBD_RESP_OKAY : CBD_RESP_SLVERR;
         case (st_q.aw_addr)
            CBD_OFF_INSTR: begin
               st_d.instr = merge_strb(st_q.instr, wr_val, st_q.w_strb);
               st_d.fsm = CBD_EVAL;
            end
            CBD_OFF_PC: begin
               st_d.pc = merge_strb(st_q.pc, wr_val, st_q.w_strb);
            end
            // RULE9 flags change only here
            CBD_OFF_FLAGS: begin
               if (st_q.w_strb[0]) begin
                  st_d.flags = wr_val[3:0];
               end
            end
            CBD_OFF_BANK: begin
               if (st_q.w_strb[0]) begin
                  st_d.bank = wr_val[CBD_BANK_W-1:0];
               end
            end
            CBD_OFF_STATUS: begin
               // write one to clear the sticky bits
               if (st_q.w_strb[0]) begin
                  st_d.never_seen = st_q.never_seen && !wr_val[CBD_ST_NEVER];
                  st_d.undef_trap = st_q.undef_trap && !wr_val[CBD_ST_UNDEF];
               end
            end
            default: begin
            end
         endcase
      end
      // sequencer
      case (st_q.fsm)
         CBD_IDLE: begin
         end
         CBD_EVAL: begin
            // RULE1 record the outcome of the condition
            st_d.exec = pass_w;
            st_d.taken = pass_w && br_w;
            st_d.linked = lm_we;
            if (dec.cond == CBD_COND_NEVER) begin
               st_d.never_seen = 1'b1;
            end
            // RULE12 only the real undefined class traps
            if (pass_w && (dec.cls == CBD_CLASS_UNDEF) && st_q.instr[4] && !mul_odd_w) begin
               st_d.undef_trap = 1'b1;
            end
            if (pass_w && br_w) begin
               // RULE5 load the target into the pc
               st_d.pc = target_w;
               st_d.fetch_cnt = CBD_PLAIN_FETCHES;
               st_d.fsm = CBD_FETCH;
            end else begin
               st_d.pc = ret_w;
               st_d.fetch_cnt = CBD_PLAIN_FETCHES;
               st_d.fsm = CBD_IDLE;
            end
         end
         CBD_FETCH: begin
            // RULE11 three fetch cycles then back to idle
            if (st_q.fetch_cnt == CBD_BRANCH_FETCHES) begin
               st_d.fsm = CBD_IDLE;
            end else begin
               st_d.fetch_cnt = st_q.fetch_cnt + 2'h1;
            end
         end
         default: begin
            st_d.fsm = CBD_IDLE;
         end
      endcase
      // read channel
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_q.arready) begin
         st_d.rvalid = 1'b1;
         st_d.rresp = CBD_RESP_OKAY;
         st_d.rdata = '0;
         case (s_axi_araddr)
            CBD_OFF_INSTR: st_d.rdata = st_q.instr;
            CBD_OFF_PC: st_d.rdata = st_q.pc;
            CBD_OFF_FLAGS: st_d.rdata[3:0] = st_q.flags;
            CBD_OFF_BANK: st_d.rdata[CBD_BANK_W-1:0] = st_q.bank;
            CBD_OFF_STATUS: begin
               st_d.rdata[CBD_ST_BUSY] = (st_q.fsm != CBD_IDLE);
               st_d.rdata[CBD_ST_EXEC] = st_q.exec;
               st_d.rdata[CBD_ST_TAKEN] = st_q.taken;
               st_d.rdata[CBD_ST_LINKED] = st_q.linked;
               st_d.rdata[CBD_ST_NEVER] = st_q.never_seen;
               st_d.rdata[CBD_ST_UNDEF] = st_q.undef_trap;
               st_d.rdata[CBD_ST_FCNT_LO +: 2] = st_q.fetch_cnt;
            end
            CBD_OFF_LINK: st_d.rdata = lm_rdata;
            default: st_d.rresp = CBD_RESP_SLVERR;
         endcase
      end
      // ready flags follow the holding state
      st_d.awready = !st_d.aw_have && !st_d.bvalid;
      st_d.wready = !st_d.w_have && !st_d.bvalid;
      st_d.arready = !st_d.rvalid;
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= CBD_STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================
   // link register store
   cbd_link_mem u_link (
      .aclk(aclk),
      .aresetn(aresetn),
      .we(lm_we),
      .waddr(st_q.bank),
      .wdata(ret_w),
      .raddr(st_q.bank),
      .rdata(lm_rdata)
   );

   // outputs straight from the state register
   assign s_axi_awready = st_q.awready;
   assign s_axi_wready = st_q.wready;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata = st_q.rdata;
   assign s_axi_rresp = st_q.rresp;

   // ==========================================
   // assertions
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence eval_taken_s;
      (st_q.fsm == CBD_EVAL) && pass_w && br_w;
   endsequence

   sequence three_fetch_s;
      (st_q.fsm == CBD_FETCH)[*3] ##1 (st_q.fsm == CBD_IDLE);
   endsequence

   // RULE1 outcome tracks condition
   cond_exec_a: assert property ((st_q.fsm == CBD_EVAL) |=> st_q.exec == $past(pass_w)) // RULE1
      else $error("executed flag does not follow condition");

   // RULE2 always condition
   always_exec_a: assert property (((st_q.fsm == CBD_EVAL) && // RULE2
                                    (dec.cond == CBD_COND_ALWAYS)) |=> st_q.exec)
      else $error("always condition did not execute");

   // RULE4 equal follows zero flag
   equal_zero_a: assert property (((st_q.fsm == CBD_EVAL) && // RULE4
                                   (dec.cond == CBD_COND_EQUAL))
                                  |=> st_q.exec == $past(st_q.flags[CBD_FLAG_Z]))
      else $error("equal condition ignores zero flag");

   // RULE5 destination address
   // RULE6 base two words ahead
   branch_target_a: assert property (eval_taken_s |=> // RULE5 RULE6
                                     st_q.pc == $past(st_q.pc) + 32'h8 +
                                     {{6{$past(st_q.instr[23])}}, $past(st_q.instr[23:0]),
                                      2'b00})
      else $error("branch target wrong");

   // RULE7 link bank and value
   // RULE8 return address
   link_value_a: assert property (lm_we |=> dec.link && st_q.linked && // RULE7 RULE8
                                  (u_link.m_q.word[$past(st_q.bank)] == $past(st_q.pc) + 32'h4))
      else $error("link write wrong");

   // RULE8 stored word reads back
   link_readback_a: assert property (lm_we ##1 (st_q.bank == $past(st_q.bank))[*2] // RULE8
                                     |-> lm_rdata == $past(ret_w, 2))
      else $error("link register lost return address");

   // RULE9 flags untouched by link
   link_flags_a: assert property (lm_we |=> $stable(st_q.flags)) // RULE9
      else $error("link action changed flags");

   // RULE10 plain branch keeps link
   plain_nolink_a: assert property (((st_q.fsm == CBD_EVAL) && br_w && !dec.link) // RULE10
                                    |=> $stable(u_link.m_q.word))
      else $error("plain branch wrote link register");

   // RULE11 three fetches
   fetch_three_a: assert property (eval_taken_s |=> three_fetch_s) // RULE11
      else $error("branch did not take three fetch cycles");

   // RULE12 odd multiply raises no trap
   mul_notrap_a: assert property (((st_q.fsm == CBD_EVAL) && mul_odd_w) // RULE12
                                  |=> st_q.undef_trap == $past(st_q.undef_trap))
      else $error("odd multiply trapped");

endmodule
